/* File: design/rxhfa_pkg.sv */
// constants for the receive highway frame alignment block
package rxhfa_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [15:0] RXHFA_IDX_BIT_CFG    = 16'h1800;
    localparam logic [15:0] RXHFA_IDX_SLOT_CFG   = 16'h1801;
    localparam logic [15:0] RXHFA_IDX_RATE_CFG   = 16'h1802;
    localparam logic [15:0] RXHFA_ADDR_BIT_CFG   = 16'h6000;
    localparam logic [15:0] RXHFA_ADDR_SLOT_CFG  = 16'h6004;
    localparam logic [15:0] RXHFA_ADDR_RATE_CFG  = 16'h6008;

    // field positions
    localparam int RXHFA_WHOLE_LSB = 4;
    localparam int RXHFA_FRAC_LSB  = 2;
    localparam int RXHFA_RESV_LSB  = 0;
    localparam int RXHFA_SLOT_LSB  = 0;
    localparam int RXHFA_LOOP_BIT  = 2;
    localparam int RXHFA_RATE_LSB  = 0;

    // reset values
    localparam logic [2:0] RXHFA_WHOLE_RST = 3'h0;
    localparam logic [1:0] RXHFA_FRAC_RST  = 2'h0;
    localparam logic [1:0] RXHFA_RESV_RST  = 2'h0;
    localparam logic [6:0] RXHFA_SLOT_RST  = 7'h00;
    localparam logic       RXHFA_LOOP_RST  = 1'b0;

    // lane rate codes
    localparam logic [1:0] RXHFA_RATE_2M   = 2'h0;
    localparam logic [1:0] RXHFA_RATE_4M   = 2'h1;
    localparam logic [1:0] RXHFA_RATE_8M   = 2'h2;
    localparam logic [1:0] RXHFA_RATE_IDLE = 2'h3;

    // largest slot index per rate
    localparam logic [6:0] RXHFA_SLOT_MAX_2M = 7'h1f;
    localparam logic [6:0] RXHFA_SLOT_MAX_4M = 7'h3f;
    localparam logic [6:0] RXHFA_SLOT_MAX_8M = 7'h7f;

    // timing: quarter steps per bit, bits per slot
    localparam logic [1:0] RXHFA_LAST_QUARTER = 2'h3;
    localparam logic [2:0] RXHFA_LAST_BIT     = 3'h7;
    localparam logic [12:0] RXHFA_QCNT_MAX    = 13'h1fff;

    // decoded register select
    localparam logic [1:0] RXHFA_SEL_NONE = 2'h0;
    localparam logic [1:0] RXHFA_SEL_BIT  = 2'h1;
    localparam logic [1:0] RXHFA_SEL_SLOT = 2'h2;
    localparam logic [1:0] RXHFA_SEL_RATE = 2'h3;

    typedef enum logic [2:0]
    {
        RXHFA_ST_IDLE  = 3'b001,
        RXHFA_ST_ARMED = 3'b010,
        RXHFA_ST_RUN   = 3'b100
    } rxhfa_state_e;
endpackage : rxhfa_pkg

/* File: design/rxhfa_top.sv */
// receive highway frame alignment with apb configuration registers
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - delay frame start by slot offset
// R2 - slot offset range follows lane rate
// R3 - software writes zero slot offset if unused
// R4 - each slot is eight bit periods
// R5 - bit period scaled per lane rate
// R6 - slot, bit, quarter offsets summed
// R7 - reserved bits read back zero; the resv bits 1:0 of the bit register are stored and read back as written
// R8 - loopback selects transmit output over pin
// R9 - software sets loopback offset half bit later
// R10 - rate code selects 2, 4, 8 or idle
// R11 - whole bit shift zero to seven
// R12 - quarter bit shift zero to three quarters
// R13 - offsets counted in quarters from frame sync
module rxhfa_top
    import rxhfa_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        frame_sync,
    input  wire logic        quarter_step,
    input  wire logic        rxd_pin,
    input  wire logic        tx_loop_in,
    output logic             rx_data,
    output logic             rx_strobe,
    output logic             rx_frame0,
    output logic [6:0]       rx_slot,
    output logic [2:0]       rx_bitpos,
    output logic             rx_enabled
);

    typedef struct packed {
        logic [2:0]   whole_bit_shift;
        logic [1:0]   quarter_bit_shift;
        logic [1:0]   resv;
        logic [6:0]   slot_shift_field;
        logic         tx_to_rx_loopback;
        logic [1:0]   lane_rate_code;
        logic         pready;
        logic [31:0]  prdata;
        logic         pslverr;
        logic [1:0]   pre;
        logic [12:0]  qcnt;
        rxhfa_state_e st;
        logic [1:0]   phase;
        logic [2:0]   bitn;
        logic [6:0]   slotn;
        logic         rx_data;
        logic         rx_strobe;
        logic         rx_frame0;
        logic         rx_enabled;
    } rxhfa_state_s;

    rxhfa_state_s r;
    rxhfa_state_s next_r;

    ////////////////////////////////////////////////////////////////////////////
    // decoders used by the bus and by the aligner
    function automatic logic [1:0] rxhfa_decode(input logic [15:0] a);
        logic [1:0] s;
        s = RXHFA_SEL_NONE;
        if (a == RXHFA_ADDR_BIT_CFG)
            s = RXHFA_SEL_BIT;
        else if (a == RXHFA_ADDR_SLOT_CFG)
            s = RXHFA_SEL_SLOT;
        else if (a == RXHFA_ADDR_RATE_CFG)
            s = RXHFA_SEL_RATE;
        return s;
    endfunction : rxhfa_decode

    // largest slot index for a rate; idle keeps the widest mask
    function automatic logic [6:0] rxhfa_slot_max(input logic [1:0] rate);
        logic [6:0] m;
        m = RXHFA_SLOT_MAX_8M;
        if (rate == RXHFA_RATE_2M)
            m = RXHFA_SLOT_MAX_2M;
        else if (rate == RXHFA_RATE_4M)
            m = RXHFA_SLOT_MAX_4M;
        return m;
    endfunction : rxhfa_slot_max

    // quarter steps of the fastest rate per quarter of this lane, minus one
    function automatic logic [1:0] rxhfa_div_mask(input logic [1:0] rate);
        logic [1:0] m;
        m = 2'h0;
        if (rate == RXHFA_RATE_2M)
            m = 2'h3;
        else if (rate == RXHFA_RATE_4M)
            m = 2'h1;
        return m;
    endfunction : rxhfa_div_mask

    ////////////////////////////////////////////////////////////////////////////
    // combinational helpers
    logic [1:0]  bus_sel;
    logic        setup_ph;
    logic        wr_take;
    logic [6:0]  slot_m;
    logic [12:0] total_off;
    logic [1:0]  eff_pre;
    logic [12:0] eff_q;
    logic        eff_arm;
    logic        lane_tick;
    logic        align_hit;
    logic        sample_now;
    logic        in_bit;

    assign bus_sel  = rxhfa_decode(paddr);
    assign setup_ph = psel && !penable;
    assign wr_take  = psel && penable && r.pready && pwrite;
    // out-of-range slot offsets wrap inside the frame of the current rate
    assign slot_m   = r.slot_shift_field & rxhfa_slot_max(r.lane_rate_code);     // [R2]
    // quarter-bit position of slot 0 bit 0 after frame sync
    assign total_off = 13'({slot_m, 5'h00})                                      // [R1] [R4]
                     + 13'({r.whole_bit_shift, 2'h0})                            // [R11]
                     + 13'(r.quarter_bit_shift);                                 // [R6] [R12]
    // frame sync restarts the quarter count in the same cycle
    assign eff_pre  = frame_sync ? 2'h0 : r.pre;                                 // [R13]
    assign eff_q    = frame_sync ? 13'h0000 : r.qcnt;
    assign eff_arm  = frame_sync || (r.st == RXHFA_ST_ARMED);
    // a lane quarter lasts 4, 2 or 1 fast quarter steps
    assign lane_tick = quarter_step && (eff_pre == 2'h0)                         // [R5]
                     && (r.lane_rate_code != RXHFA_RATE_IDLE);                   // [R10]
    assign align_hit  = lane_tick && eff_arm && (eff_q == total_off);
    assign sample_now = align_hit
                     || (lane_tick && (r.st == RXHFA_ST_RUN) && (r.phase == 2'h0));
    assign in_bit = r.tx_to_rx_loopback ? tx_loop_in : rxd_pin;                  // [R8]

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_r           = r;
        next_r.rx_strobe = 1'b0;
        next_r.rx_frame0 = 1'b0;
        next_r.rx_enabled = (r.lane_rate_code != RXHFA_RATE_IDLE);
        // apb: answer one cycle after setup, data loaded with pready
        next_r.pready  = setup_ph;
        next_r.pslverr = setup_ph && (bus_sel == RXHFA_SEL_NONE);
        next_r.prdata  = 32'h0000_0000;
        if (setup_ph && !pwrite)
        begin
            unique case (bus_sel)
                RXHFA_SEL_BIT:  next_r.prdata = {24'h000000, 1'b0,                // [R7]
                                    r.whole_bit_shift, r.quarter_bit_shift, r.resv};
                RXHFA_SEL_SLOT: next_r.prdata = {24'h000000, 1'b0,                // [R7]
                                    r.slot_shift_field};
                RXHFA_SEL_RATE: next_r.prdata = {29'h00000000,                    // [R7]
                                    r.tx_to_rx_loopback, r.lane_rate_code};
                RXHFA_SEL_NONE: next_r.prdata = 32'h0000_0000;
            endcase
        end
        if (wr_take)
        begin
            unique case (bus_sel)
                RXHFA_SEL_BIT:
                begin
                    next_r.whole_bit_shift   = pwdata[RXHFA_WHOLE_LSB +: 3];     // [R11]
                    next_r.quarter_bit_shift = pwdata[RXHFA_FRAC_LSB +: 2];      // [R12]
                    next_r.resv              = pwdata[RXHFA_RESV_LSB +: 2];
                end
                RXHFA_SEL_SLOT: next_r.slot_shift_field = pwdata[RXHFA_SLOT_LSB +: 7];
                RXHFA_SEL_RATE:
                begin
                    next_r.tx_to_rx_loopback = pwdata[RXHFA_LOOP_BIT];           // [R8]
                    next_r.lane_rate_code    = pwdata[RXHFA_RATE_LSB +: 2];      // [R10]
                end
                RXHFA_SEL_NONE: next_r.pslverr = 1'b0;                   // error shown once
            endcase
        end
        // prescaler of fast quarter steps down to lane quarters
        if (frame_sync)
        begin
            next_r.pre  = 2'h0;
            next_r.qcnt = 13'h0000;
            if (r.st != RXHFA_ST_RUN)
                next_r.st = RXHFA_ST_ARMED;
        end
        if (quarter_step)
            next_r.pre = (eff_pre + 2'h1) & rxhfa_div_mask(r.lane_rate_code);   // [R5]
        // saturate so a missing sync cannot fake a late alignment
        if (lane_tick && (eff_q != RXHFA_QCNT_MAX))
            next_r.qcnt = eff_q + 13'h0001;                                      // [R13]
        // stays armed across sync until the offset is reached
        if (frame_sync && (r.st == RXHFA_ST_RUN))
            next_r.st = RXHFA_ST_ARMED;
        if (align_hit)
        begin
            next_r.st        = RXHFA_ST_RUN;                                     // [R1] [R6]
            next_r.phase     = 2'h1;
            next_r.bitn      = 3'h0;
            next_r.slotn     = 7'h00;
            next_r.rx_frame0 = 1'b1;
        end
        else if (lane_tick && (r.st == RXHFA_ST_RUN))
        begin
            next_r.phase = (r.phase == RXHFA_LAST_QUARTER) ? 2'h0 : r.phase + 2'h1;
            if (r.phase == 2'h0)
            begin
                // eight bits make a slot, slots wrap at the rate's frame
                next_r.bitn = r.bitn + 3'h1;                                     // [R4]
                if (r.bitn == RXHFA_LAST_BIT)
                    next_r.slotn = (r.slotn == rxhfa_slot_max(r.lane_rate_code))
                                 ? 7'h00 : r.slotn + 7'h01;                      // [R2]
            end
        end
        if (sample_now)
        begin
            next_r.rx_strobe = 1'b1;
            next_r.rx_data   = in_bit;                                           // [R8]
        end
        // idle lane drops out of alignment and reports nothing
        if (r.lane_rate_code == RXHFA_RATE_IDLE)
            next_r.st = RXHFA_ST_IDLE;                                           // [R10]
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r                   <= '0;
            r.whole_bit_shift   <= RXHFA_WHOLE_RST;
            r.quarter_bit_shift <= RXHFA_FRAC_RST;
            r.resv              <= RXHFA_RESV_RST;
            r.slot_shift_field  <= RXHFA_SLOT_RST;
            r.tx_to_rx_loopback <= RXHFA_LOOP_RST;
            r.lane_rate_code    <= RXHFA_RATE_2M;
            r.st                <= RXHFA_ST_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign pready     = r.pready;
    assign prdata     = r.prdata;
    assign pslverr    = r.pslverr;
    assign rx_data    = r.rx_data;
    assign rx_strobe  = r.rx_strobe;
    assign rx_frame0  = r.rx_frame0;
    assign rx_slot    = r.slotn;
    assign rx_bitpos  = r.bitn;
    assign rx_enabled = r.rx_enabled;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic rd_rate;
    logic rd_slot;
    logic [2:0] last_bit;
    assign rd_rate = setup_ph && !pwrite && (bus_sel == RXHFA_SEL_RATE);
    assign rd_slot = setup_ph && !pwrite && (bus_sel == RXHFA_SEL_SLOT);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            last_bit <= 3'h0;
        else if (r.rx_strobe)
            last_bit <= r.bitn;
    end

    // fast steps since the last lane tick; a rate write or bare sync voids the count
    logic [2:0]  step_gap;
    logic [1:0]  gap_rate;
    logic [12:0] want_off;
    assign want_off = {1'b0, slot_m, r.whole_bit_shift, r.quarter_bit_shift};
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            step_gap <= 3'h0;
            gap_rate <= RXHFA_RATE_IDLE;
        end
        else
        begin
            if (lane_tick || frame_sync)
                step_gap <= 3'h0;
            else if (quarter_step && (step_gap != 3'h7))
                step_gap <= step_gap + 3'h1;
            if (wr_take && (bus_sel == RXHFA_SEL_RATE))
                gap_rate <= RXHFA_RATE_IDLE;
            else if (lane_tick || frame_sync)
                gap_rate <= lane_tick ? r.lane_rate_code : RXHFA_RATE_IDLE;
        end
    end

    frame_align_a: assert property (rx_frame0 |-> $past(eff_q) == $past(want_off))   // [R1]
        else $error("alignment off its programmed quarter");
    frame0_pos_a: assert property (rx_frame0 |-> rx_strobe && rx_slot == 7'h00
                                  && rx_bitpos == 3'h0)                              // [R6]
        else $error("frame start not at slot 0 bit 0");
    slot_range_a: assert property (rx_strobe && $stable(r.lane_rate_code)
                                  |-> rx_slot <= rxhfa_slot_max(r.lane_rate_code))   // [R2]
        else $error("slot index beyond frame");
    bit_step_a: assert property (rx_strobe && !rx_frame0
                                |-> rx_bitpos == 3'(last_bit + 3'h1))                // [R4]
        else $error("bit position skipped");
    idle_quiet_a: assert property (r.lane_rate_code == RXHFA_RATE_IDLE
                                  |=> !rx_strobe && !rx_enabled)                     // [R10]
        else $error("idle lane produced a sample");
    rate_rd_a: assert property (rd_rate |=> prdata[31:3] == 29'h00000000)            // [R7]
        else $error("rate byte reserved bits set");
    slot_rd_a: assert property (rd_slot |=> prdata[31:7] == 25'h0000000)             // [R7]
        else $error("slot byte reserved bits set");
    loop_src_a: assert property (sample_now && r.tx_to_rx_loopback
                                |=> rx_data == $past(tx_loop_in))                    // [R8]
        else $error("loopback data not from transmit");
    pin_src_a: assert property (sample_now && !r.tx_to_rx_loopback
                               |=> rx_data == $past(rxd_pin))                        // [R8]
        else $error("pin data not sampled");
    lane_spacing_a: assert property (lane_tick && !frame_sync && gap_rate == RXHFA_RATE_2M // [R5]
                                    && r.lane_rate_code == RXHFA_RATE_2M |-> step_gap == 3'h3)
        else $error("slow lane quarter spacing wrong");
    apb_ready_a: assert property (setup_ph |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    loop_cov_c: cover property (rx_strobe && r.tx_to_rx_loopback);
    fast_cov_c: cover property (rx_frame0 && r.lane_rate_code == RXHFA_RATE_8M);
    wrap_cov_c: cover property (rx_strobe && rx_slot == RXHFA_SLOT_MAX_2M
                               && rx_bitpos == RXHFA_LAST_BIT);
    frac_cov_c: cover property (rx_frame0 && r.quarter_bit_shift != 2'h0);

endmodule : rxhfa_top

/* File: testbench/rxhfa_hwy_model.sv */
// behavioural tdm highway device: shared frame sync, quarter steps, line level
module rxhfa_hwy_model
#(
    parameter int FRAME_LEN = 4200
)
(
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic slow,
    input  wire logic pin_lvl,
    output logic      frame_sync,
    output logic      quarter_step,
    output logic      rxd_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    int   cnt;
    logic run;

    ////////////////////////////////////////////////////////////////////////////
    // free running frame counter; no sync until out of reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt <= 0;
            run <= 1'b0;
        end
        else
        begin
            run <= 1'b1;
            cnt <= (cnt == FRAME_LEN - 1) ? 0 : cnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync always lands on a step; slow mode halves the step rate
    assign frame_sync   = run && (cnt == 0);
    assign quarter_step = run && (!slow || cnt[0] == 1'b0); // frame length kept even
    assign rxd_pin      = pin_lvl;           // line is always driven inside frames
endmodule : rxhfa_hwy_model

/* File: testbench/testbench.sv */
// self-checking bench: apb register access and receive frame alignment
module testbench
    import rxhfa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, er;
    logic        frame_sync, quarter_step, rxd_pin, tx_loop_in, slow, pin_lvl;
    logic        rx_data, rx_strobe, rx_frame0, rx_enabled;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0]  rx_slot;
    logic [2:0]  rx_bitpos;
    int          err_total, tests_run, n, q, dv, sp;
    // alignment cases: rate, slot, whole, quarter, slow steps, loopback, pin
    int          t_rate  [8] = '{2, 2, 1, 1, 0, 0, 2, 2};
    int          t_slot  [8] = '{0, 127, 63, 64, 33, 0, 0, 0};
    int          t_whole [8] = '{0, 7, 1, 0, 2, 0, 1, 0};
    int          t_frac  [8] = '{0, 3, 2, 1, 3, 0, 1, 2};
    int          t_slow  [8] = '{0, 0, 0, 0, 0, 0, 1, 0};
    int          t_loop  [8] = '{0, 0, 0, 0, 0, 1, 0, 1};
    int          t_pin   [8] = '{1, 0, 1, 1, 0, 1, 1, 0};
    logic [15:0] t_addr  [3] = '{RXHFA_ADDR_BIT_CFG, RXHFA_ADDR_SLOT_CFG, RXHFA_ADDR_RATE_CFG};
    logic [31:0] t_mask  [3] = '{32'h0000007f, 32'h0000007f, 32'h00000007};

    ////////////////////////////////////////////////////////////////////////////
    rxhfa_top rxhfa_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .frame_sync(frame_sync), .quarter_step(quarter_step),
        .rxd_pin(rxd_pin), .tx_loop_in(tx_loop_in), .rx_data(rx_data), .rx_strobe(rx_strobe),
        .rx_frame0(rx_frame0), .rx_slot(rx_slot), .rx_bitpos(rx_bitpos),
        .rx_enabled(rx_enabled));

    rxhfa_hwy_model #(.FRAME_LEN(4200)) rxhfa_hwy_model_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .slow(slow), .pin_lvl(pin_lvl), .frame_sync(frame_sync),
        .quarter_step(quarter_step), .rxd_pin(rxd_pin));

    // 10 MHz system clock
    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // one apb transfer; setup, then access held until pready is sampled high
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            chk("pready wait", 1, 0);
            end_sim();
        end
    endtask : apb

    // edges until sync (0), frame start (1) or strobe (2) is sampled high
    task automatic count_to(input int sel, output int c);
        logic hit;
        c = 0;
        hit = 1'b0;
        while (!hit)
        begin
            @(posedge clk_sys);
            c++;
            hit = (sel == 0) ? frame_sync === 1'b1 :
                  (sel == 1) ? rx_frame0 === 1'b1 : rx_strobe === 1'b1;
            if (!hit && c > 9000)
            begin
                chk("event wait", 1, 0);
                end_sim();
            end
        end
    endtask : count_to

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        tx_loop_in = 1'b0;
        slow = 1'b0;
        pin_lvl = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("rx_enabled reset", 1, rx_enabled);
        // reset values, then unused upper bits forced to zero (resv bits read back as written)
        for (int i = 0; i < 3; i++)
        begin
            apb(t_addr[i], 1'b0, 32'h00000000);
            chk("reg reset", 0, rd);
            apb(t_addr[i], 1'b1, 32'hffffffff);
            apb(t_addr[i], 1'b0, 32'h00000000);
            chk("reg readback", t_mask[i], rd);
        end
        apb(16'h600c, 1'b1, 32'h00000055);
        chk("unmapped wr err", 1, er);
        apb(16'h600c, 1'b0, 32'h00000000);
        chk("unmapped rd err", 1, er);
        chk("unmapped rd data", 0, rd);
        // rate register now holds the idle code: nothing may be received
        repeat (2) @(posedge clk_sys);
        chk("rx_enabled idle", 0, rx_enabled);
        n = 0;
        repeat (5000)
        begin
            @(posedge clk_sys);
            if (rx_strobe === 1'b1)
                n++;
        end
        chk("idle strobes", 0, n);
        $display("test registers done");
        // each case: delay from sync to slot 0 bit 0, then bit spacing
        for (int i = 0; i < 8; i++)
        begin
            dv = (t_rate[i] == 2) ? 1 : (t_rate[i] == 1) ? 2 : 4;
            q = (t_slot[i] % (128 / dv)) * 32 + t_whole[i] * 4 + t_frac[i];
            sp = 4 * dv * (t_slow[i] + 1);
            slow <= (t_slow[i] != 0);
            pin_lvl <= (t_pin[i] != 0);
            tx_loop_in <= (t_pin[i] == 0);
            apb(RXHFA_ADDR_BIT_CFG, 1'b1, t_whole[i] * 16 + t_frac[i] * 4);
            apb(RXHFA_ADDR_SLOT_CFG, 1'b1, t_slot[i]);
            apb(RXHFA_ADDR_RATE_CFG, 1'b1, t_loop[i] * 4 + t_rate[i]);
            count_to(0, n);
            count_to(1, n);
            chk("frame0 delay", dv * q * (t_slow[i] + 1) + 1, n);
            chk("frame0 position", 0, {rx_slot, rx_bitpos});
            chk("rx_data", (t_loop[i] != 0) ? t_pin[i] == 0 : t_pin[i] != 0, rx_data);
            for (int k = 1; k <= 8; k++)
            begin
                count_to(2, n);
                chk("strobe gap", sp, n);
            end
            chk("next slot", 32'h00000008, {rx_slot, rx_bitpos});
            $display("test align %0d done", i);
        end
        end_sim();
    end
endmodule : testbench
